// ### src/tcr_pkg.sv
/*
  Constants, field layouts and carrier types of the transceiver control register bank.
  Assumes a 10 MHz reference clock and 32-bit Avalon-MM word access.
*/
package tcr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned IDX_LO = 2;

  // ==========================================================================
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_GENERAL_CONTROL   = 6'h01;
  localparam logic [IDX_W-1:0] IDX_LEVEL_SOFT_RESET  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_RX_FREQ_WORD      = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_RX_GAIN_WORD      = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_OFFSET_THRESHOLDS = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_RX_BASEBAND_MODE  = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_STATUS            = 6'h10;

  // ==========================================================================
  // Field positions
  localparam int unsigned GC_TX_BAND_BIT   = 4;
  localparam int unsigned GC_TX_SYNTH_BIT  = 3;
  localparam int unsigned GC_RX_BAND_HI    = 2;
  localparam int unsigned GC_RX_BAND_LO    = 1;
  localparam int unsigned GC_RX_SYNTH_BIT  = 0;
  localparam int unsigned LS_LEVEL_BIT     = 1;
  localparam int unsigned LS_SOFT_RST_BIT  = 0;
  localparam int unsigned GAIN_W           = 7;
  localparam int unsigned OT_SKIP_HI       = 15;
  localparam int unsigned OT_SKIP_LO       = 12;
  localparam int unsigned OT_MIX_HI        = 7;
  localparam int unsigned OT_MIX_LO        = 4;
  localparam int unsigned OT_LNA_HI        = 3;
  localparam int unsigned OT_LNA_LO        = 0;
  localparam int unsigned BB_BW_HI         = 8;
  localparam int unsigned BB_BW_LO         = 6;
  localparam int unsigned BB_CAL_HI        = 5;
  localparam int unsigned BB_CAL_LO        = 1;
  localparam int unsigned BB_NARROW_BIT    = 8;

  // ==========================================================================
  // Receive band codes
  localparam logic [1:0] RX_BAND_RESERVED = 2'h0;
  localparam logic [1:0] RX_BAND_LOW      = 2'h1;
  localparam logic [1:0] RX_BAND_HIGH_ONE = 2'h2;
  localparam logic [1:0] RX_BAND_HIGH_TWO = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [REG_W-1:0] RST_GENERAL_CONTROL   = 16'h0004;
  localparam logic [REG_W-1:0] RST_LEVEL_SOFT_RESET  = 16'h0002;
  localparam logic [REG_W-1:0] RST_RX_FREQ_WORD      = 16'h9858;
  localparam logic [REG_W-1:0] RST_RX_GAIN_WORD      = 16'h0000;
  localparam logic [REG_W-1:0] RST_OFFSET_THRESHOLDS = 16'h0FA6;
  localparam logic [REG_W-1:0] RST_RX_BASEBAND_MODE  = 16'h0890;

  // ==========================================================================
  // Gain arithmetic, signed 9-bit working width
  localparam int unsigned      GSUM_W        = 9;
  localparam logic [GSUM_W-1:0] GAIN_X_WIDE   = 9'h008;
  localparam logic [GSUM_W-1:0] GAIN_X_NARROW = 9'h011;
  localparam logic [GSUM_W-1:0] GAIN_MIN      = 9'h00C;
  localparam logic [GSUM_W-1:0] GAIN_MAX      = 9'h066;
  localparam logic [GSUM_W-1:0] GAIN_CEIL     = 9'h07F;
  localparam logic [3:0]        MIX_STEP_CLIP = 4'h6;
  localparam logic [3:0]        LNA_STEP_CLIP = 4'hA;

  // ==========================================================================
  // Soft reset timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned SOFT_RST_NS     = 50000;
  localparam int unsigned SOFT_RST_CYC    =
    (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W       = 10;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    TCR_SR_IDLE  = 2'b01,
    TCR_SR_PULSE = 2'b10
  } tcr_sr_state_e;

  typedef struct packed {
    logic       tx_high_band_select;
    logic       tx_synth_en;
    logic       rx_synth_en;
    logic [1:0] rx_band_select;
    logic       serial_io_level_select;
  } tcr_ctrl_s;

  typedef struct packed {
    logic [REG_W-1:0]  rx_freq_word;
    logic [GAIN_W-1:0] rx_gain_eff;
    logic [3:0]        rf_skip;
  } tcr_rx_s;

endpackage

// ### src/tcr_regs.sv
/*
  Transceiver control register bank: Avalon-MM slave, control outputs,
  soft reset pulse generator and receive gain computation.
  Assumes one 10 MHz clock, synchronous active-low reset, and a master that
  holds its request until waitrequest is sampled low.
*/
// ==========================================================================
// Summary of operation
// RL1: General control bit 4 routes transmit to the low band when 0 and high band when 1.
// RL2: General control bit 3 enables the transmit synthesizer, bit 0 the receive synthesizer.
// RL3: Receive band bits 2:1 pick 01 low, 10 high one (default), 11 high two; 00 reserved.
// RL4: Register 2 bit 1 picks 1.8 V when 0 and 2.8 V when 1, 2.8 V after any reset.
// RL5: A rising edge written to register 2 bit 0 starts a 50 us full-chip reset pulse.
// RL6: The soft-reset request bit clears itself without a software write.
// RL7: Software is advised to issue a soft reset after power-up before other setup.
// RL8: The 16-bit receive frequency word sets the synthesizer in 50 kHz steps.
// RL9: Software writes channel frequency for high bands and twice it for the low band.
// RL10: The seven-bit receive gain word weighs 1 dB per step, 0 to 127 dB.
// RL11: Effective gain is gain word minus calibration plus 8 wideband or 17 narrowband.
// RL12: With mixer threshold 6 and amplifier threshold 10 gain is clipped to 12..102 dB.
// RL13: Register 12 bits 15:12 mark offset states 3..0 skipped without a gain step, default 0.
// RL14: The pulse is counted on the reference clock and reloads on every request edge.
`timescale 1ns/1ps
`default_nettype none

module tcr_regs (
  input  wire logic                        ref_clk_i,
  input  wire logic                        resetn_i,
  input  wire logic [tcr_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [tcr_pkg::DATA_W-1:0]  avs_writedata_i,
  output logic      [tcr_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                             avs_waitrequest_o,
  output tcr_pkg::tcr_ctrl_s               ctrl_o,
  output tcr_pkg::tcr_rx_s                 rx_o,
  output logic                             chip_reset_o
);
  import tcr_pkg::*;

  // ==========================================================================
  // Decode
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
    hit = (addr[ADDR_W-1:IDX_LO] == idx);
  endfunction

  logic                 ack_q;
  logic                 wr_take;
  logic [REG_W-1:0]     wdata;
  logic [REG_W-1:0]     gen_ctrl_q;
  logic [REG_W-1:0]     level_q;
  logic [REG_W-1:0]     rx_freq_q;
  logic [REG_W-1:0]     rx_gain_q;
  logic [REG_W-1:0]     thresh_q;
  logic [REG_W-1:0]     bb_mode_q;
  logic                 req_q;
  logic                 req_edge;
  tcr_sr_state_e        sr_state_q;
  logic [RST_CNT_W-1:0] sr_cnt_q;
  logic                 pulse_end;
  logic                 regs_rst;
  logic [GSUM_W-1:0]    gain_sum;
  logic [GSUM_W-1:0]    gain_d;
  logic                 gain_clipped;
  logic [DATA_W-1:0]    rdata_d;
  logic [DATA_W-1:0]    rdata_q;
  logic [GAIN_W-1:0]    gain_q;

  // ==========================================================================
  // Avalon-MM handshake: one wait cycle, then the transfer completes
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_take           = avs_write_i & ack_q;
  assign wdata             = avs_writedata_i[REG_W-1:0];

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  // ==========================================================================
  // Soft reset request edge and pulse
  assign req_edge  = wr_take & hit(avs_address_i, IDX_LEVEL_SOFT_RESET)
                   & wdata[LS_SOFT_RST_BIT] & ~req_q;
  assign pulse_end = (sr_state_q == TCR_SR_PULSE) && (sr_cnt_q == '0);
  assign regs_rst  = !resetn_i || (sr_state_q == TCR_SR_PULSE);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      req_q <= 1'b0;
    end else if (req_edge) begin
      req_q <= 1'b1;
    end else if (pulse_end) begin
      req_q <= 1'b0; // [RL6]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sr_state_q <= TCR_SR_IDLE;
      sr_cnt_q   <= '0;
    end else if (req_edge) begin
      sr_state_q <= TCR_SR_PULSE; // [RL5]
      sr_cnt_q   <= RST_CNT_W'(SOFT_RST_CYC - 1); // [RL14]
    end else begin
      case (sr_state_q)
        TCR_SR_IDLE: begin
          sr_cnt_q <= '0;
        end
        TCR_SR_PULSE: begin
          if (sr_cnt_q == '0) begin
            sr_state_q <= TCR_SR_IDLE;
          end else begin
            sr_cnt_q <= sr_cnt_q - 1'b1; // [RL14]
          end
        end
        default: begin
          sr_state_q <= TCR_SR_IDLE;
          sr_cnt_q   <= '0;
        end
      endcase
    end
  end

  assign chip_reset_o = (sr_state_q == TCR_SR_PULSE); // [RL5]

  // ==========================================================================
  // Configuration registers, returned to defaults by either reset
  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      gen_ctrl_q <= RST_GENERAL_CONTROL; // [RL3]
    end else if (wr_take && hit(avs_address_i, IDX_GENERAL_CONTROL)) begin
      gen_ctrl_q <= wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      level_q <= RST_LEVEL_SOFT_RESET; // [RL4]
    end else if (wr_take && hit(avs_address_i, IDX_LEVEL_SOFT_RESET)) begin
      level_q <= wdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      rx_freq_q <= RST_RX_FREQ_WORD;
    end else if (wr_take && hit(avs_address_i, IDX_RX_FREQ_WORD)) begin
      rx_freq_q <= wdata; // [RL8]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      rx_gain_q <= RST_RX_GAIN_WORD;
    end else if (wr_take && hit(avs_address_i, IDX_RX_GAIN_WORD)) begin
      rx_gain_q <= wdata; // [RL10]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      thresh_q <= RST_OFFSET_THRESHOLDS;
    end else if (wr_take && hit(avs_address_i, IDX_OFFSET_THRESHOLDS)) begin
      thresh_q <= wdata; // [RL13]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (regs_rst) begin
      bb_mode_q <= RST_RX_BASEBAND_MODE;
    end else if (wr_take && hit(avs_address_i, IDX_RX_BASEBAND_MODE)) begin
      bb_mode_q <= wdata;
    end
  end

  // ==========================================================================
  // Control outputs straight from register fields, effective gain from gain_q
  assign ctrl_o.tx_high_band_select    = gen_ctrl_q[GC_TX_BAND_BIT]; // [RL1]
  assign ctrl_o.tx_synth_en            = gen_ctrl_q[GC_TX_SYNTH_BIT]; // [RL2]
  assign ctrl_o.rx_synth_en            = gen_ctrl_q[GC_RX_SYNTH_BIT]; // [RL2]
  assign ctrl_o.rx_band_select         = gen_ctrl_q[GC_RX_BAND_HI:GC_RX_BAND_LO]; // [RL3]
  assign ctrl_o.serial_io_level_select = level_q[LS_LEVEL_BIT]; // [RL4]
  assign rx_o.rx_freq_word             = rx_freq_q; // [RL8]
  assign rx_o.rf_skip                  = thresh_q[OT_SKIP_HI:OT_SKIP_LO]; // [RL13]
  assign rx_o.rx_gain_eff              = gain_q;

  // ==========================================================================
  // Effective receive gain
  always_comb begin
    gain_sum = GSUM_W'(rx_gain_q[GAIN_W-1:0])
             - GSUM_W'(bb_mode_q[BB_CAL_HI:BB_CAL_LO])
             + (bb_mode_q[BB_NARROW_BIT] ? GAIN_X_NARROW : GAIN_X_WIDE); // [RL11]
    gain_clipped = (thresh_q[OT_MIX_HI:OT_MIX_LO] == MIX_STEP_CLIP)
                && (thresh_q[OT_LNA_HI:OT_LNA_LO] == LNA_STEP_CLIP);
    if (gain_clipped && ($signed(gain_sum) < $signed(GAIN_MIN))) begin
      gain_d = GAIN_MIN; // [RL12]
    end else if (gain_clipped && ($signed(gain_sum) > $signed(GAIN_MAX))) begin
      gain_d = GAIN_MAX; // [RL12]
    end else if ($signed(gain_sum) < 0) begin
      gain_d = '0;
    end else if ($signed(gain_sum) > $signed(GAIN_CEIL)) begin
      gain_d = GAIN_CEIL; // [RL10]
    end else begin
      gain_d = gain_sum;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      gain_q <= '0;
    end else begin
      gain_q <= gain_d[GAIN_W-1:0];
    end
  end

  // ==========================================================================
  // Read path: only the status word is readable
  always_comb begin
    rdata_d = '0;
    if (hit(avs_address_i, IDX_STATUS)) begin
      rdata_d = {15'h0000, gain_clipped, 7'h00, gain_q, 1'b0, chip_reset_o};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_o = rdata_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  int unsigned pulse_len;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !chip_reset_o) begin
      pulse_len <= 0;
    end else begin
      pulse_len <= pulse_len + 1;
    end
  end

  tx_band_route_a: assert property ( // [RL1]
    !regs_rst && $past(wr_take && hit(avs_address_i, IDX_GENERAL_CONTROL) && !regs_rst)
    |-> ctrl_o.tx_high_band_select == $past(wdata[GC_TX_BAND_BIT]))
    else $error("transmit band not taken from write");
  synth_enable_a: assert property ( // [RL2]
    !regs_rst && $past(wr_take && hit(avs_address_i, IDX_GENERAL_CONTROL) && !regs_rst)
    |-> {ctrl_o.tx_synth_en, ctrl_o.rx_synth_en}
        == {$past(wdata[GC_TX_SYNTH_BIT]), $past(wdata[GC_RX_SYNTH_BIT])})
    else $error("synth enables not taken from write");
  rx_band_route_a: assert property ( // [RL3]
    !regs_rst && $past(wr_take && hit(avs_address_i, IDX_GENERAL_CONTROL) && !regs_rst)
    |-> ctrl_o.rx_band_select == $past(wdata[GC_RX_BAND_HI:GC_RX_BAND_LO]))
    else $error("receive band not taken from write");
  rx_band_default_a: assert property ( // [RL3]
    $fell(chip_reset_o) |-> ctrl_o.rx_band_select == RX_BAND_HIGH_ONE)
    else $error("receive band not default after soft reset");
  level_default_a: assert property ( // [RL4]
    chip_reset_o |=> ctrl_o.serial_io_level_select)
    else $error("interface level not 2.8 V during reset");
  level_write_a: assert property ( // [RL4]
    !regs_rst && $past(wr_take && hit(avs_address_i, IDX_LEVEL_SOFT_RESET) && !regs_rst)
    |-> ctrl_o.serial_io_level_select == $past(wdata[LS_LEVEL_BIT]))
    else $error("interface level not taken from write");
  pulse_start_a: assert property ( // [RL5]
    req_edge |=> chip_reset_o [*8])
    else $error("soft reset pulse did not start");
  pulse_cause_a: assert property ( // [RL5]
    $rose(chip_reset_o) |-> $past(req_edge))
    else $error("soft reset pulse without request");
  pulse_hold_a: assert property ( // [RL5]
    chip_reset_o |=> rx_o.rx_freq_word == RST_RX_FREQ_WORD)
    else $error("frequency word not held at default during reset");
  pulse_length_a: assert property ( // [RL14]
    $fell(chip_reset_o) |-> $past(pulse_len) == SOFT_RST_CYC - 1)
    else $error("soft reset pulse length wrong");
  req_self_clear_a: assert property ( // [RL6]
    $fell(chip_reset_o) |-> !req_q)
    else $error("request bit not cleared");
  req_held_a: assert property ( // [RL6]
    chip_reset_o |-> req_q)
    else $error("request bit dropped during pulse");
  freq_word_a: assert property ( // [RL8]
    !regs_rst && $past(wr_take && hit(avs_address_i, IDX_RX_FREQ_WORD) && !regs_rst)
    |-> rx_o.rx_freq_word == $past(wdata))
    else $error("frequency word not updated");
  gain_clip_a: assert property ( // [RL12]
    $past(gain_clipped)
    |-> rx_o.rx_gain_eff inside {[GAIN_MIN[GAIN_W-1:0]:GAIN_MAX[GAIN_W-1:0]]})
    else $error("gain outside clip range");
  gain_floor_a: assert property ( // [RL12]
    $past(gain_clipped && $signed(gain_sum) < $signed(GAIN_MIN))
    |-> rx_o.rx_gain_eff == GAIN_MIN[GAIN_W-1:0])
    else $error("gain not raised to clip floor");
  gain_top_a: assert property ( // [RL12]
    $past(gain_clipped && $signed(gain_sum) > $signed(GAIN_MAX))
    |-> rx_o.rx_gain_eff == GAIN_MAX[GAIN_W-1:0])
    else $error("gain not lowered to clip top");
  gain_formula_a: assert property ( // [RL11]
    $past(!gain_clipped && $signed(gain_sum) >= 0 && $signed(gain_sum) <= 127)
    |-> rx_o.rx_gain_eff == $past(gain_sum[GAIN_W-1:0]))
    else $error("gain formula mismatch");
  gain_range_a: assert property ( // [RL10]
    $past(!gain_clipped && $signed(gain_sum) > $signed(GAIN_CEIL))
    |-> rx_o.rx_gain_eff == GAIN_CEIL[GAIN_W-1:0])
    else $error("gain not saturated at word top");
  skip_default_a: assert property ( // [RL13]
    $fell(chip_reset_o) |-> rx_o.rf_skip == RST_OFFSET_THRESHOLDS[OT_SKIP_HI:OT_SKIP_LO])
    else $error("skip field not default");

  // ==========================================================================
  // Bus handshake and read path checks
  wait_one_a: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  read_zero_a: assert property (
    avs_read_i && avs_waitrequest_o && !hit(avs_address_i, IDX_STATUS)
    |=> avs_readdata_o == '0)
    else $error("write-only or unmapped register read nonzero");

  // ==========================================================================
  // Scenario covers
  soft_reset_c: cover property (req_edge ##1 chip_reset_o);
  gain_floor_c: cover property (gain_clipped && $signed(gain_sum) < $signed(GAIN_MIN));
  gain_clip_c:  cover property (gain_clipped && $signed(gain_sum) > $signed(GAIN_MAX));
  band_write_c: cover property (wr_take && hit(avs_address_i, IDX_GENERAL_CONTROL));
  status_rd_c:  cover property (avs_read_i && ack_q && hit(avs_address_i, IDX_STATUS));

endmodule

`default_nettype wire

// ### tb/tcr_host_model.sv
/*
  Host model: Avalon-MM master issuing single register transfers.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module tcr_host_model (
  input  wire logic                        ref_clk_i,
  input  wire logic                        waitrequest_i,
  input  wire logic [tcr_pkg::DATA_W-1:0]  readdata_i,
  output logic      [tcr_pkg::ADDR_W-1:0]  address_o,
  output logic                             read_o,
  output logic                             write_o,
  output logic      [tcr_pkg::DATA_W-1:0]  writedata_o
);
  import tcr_pkg::*;

  localparam int MAX_WAIT = 50;

  initial begin
    address_o   = 8'h00;
    read_o      = 1'b0;
    write_o     = 1'b0;
    writedata_o = 32'h0000_0000;
  end

  // ==========================================================================
  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic is_wr, input logic [IDX_W-1:0] idx, input logic [15:0] data,
                      output logic [31:0] rdata, output logic ok);
    int n;
    ok    = 1'b0;
    rdata = 32'h0000_0000;
    @(posedge ref_clk_i);
    address_o   <= {idx, 2'h0};
    writedata_o <= {16'h0000, data};
    write_o     <= is_wr;
    read_o      <= ~is_wr;
    for (n = 0; n < MAX_WAIT && !ok; n++) begin
      @(posedge ref_clk_i);
      if (waitrequest_i === 1'b0) begin
        ok    = 1'b1;
        rdata = readdata_i;
      end
    end
    write_o     <= 1'b0;
    read_o      <= 1'b0;
    // Stale data must not look like a held request
    writedata_o <= ~writedata_o;
  endtask

  // ==========================================================================
  // Low band runs the synthesizer at twice the channel
  function automatic logic [15:0] freq_word(input int chan_khz, input logic low_band);
    return 16'((low_band ? 2 * chan_khz : chan_khz) / 50);
  endfunction

endmodule
`default_nettype wire

// ### tb/tcr_regs_test.sv
/*
  Self-checking bench of the transceiver control register bank.
  Assumes the host model drives the bus; expectations come from bench functions.
*/
`timescale 1ns/1ps
`default_nettype none

module tcr_regs_test;
  import tcr_pkg::*;

  logic                ref_clk;
  logic                resetn;
  logic [ADDR_W-1:0]   address;
  logic                read;
  logic                write;
  logic [DATA_W-1:0]   writedata;
  logic [DATA_W-1:0]   readdata;
  logic                waitrequest;
  tcr_ctrl_s           ctrl;
  tcr_rx_s             rx;
  logic                chip_reset;
  int                  bad_count;
  int                  n_compared;
  int                  seed;
  int                  i;
  int                  len;
  logic [31:0]         r;
  logic [15:0]         d;
  logic [6:0]          g_exp;

  tcr_regs i_dut (
    .ref_clk_i         (ref_clk),
    .resetn_i          (resetn),
    .avs_address_i     (address),
    .avs_read_i        (read),
    .avs_write_i       (write),
    .avs_writedata_i   (writedata),
    .avs_readdata_o    (readdata),
    .avs_waitrequest_o (waitrequest),
    .ctrl_o            (ctrl),
    .rx_o              (rx),
    .chip_reset_o      (chip_reset)
  );

  tcr_host_model i_host (
    .ref_clk_i     (ref_clk),
    .waitrequest_i (waitrequest),
    .readdata_i    (readdata),
    .address_o     (address),
    .read_o        (read),
    .write_o       (write),
    .writedata_o   (writedata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Reporting
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic is_wr, input logic [5:0] idx, input logic [15:0] data,
                     output logic [31:0] rdata);
    logic ok;
    i_host.xfer(is_wr, idx, data, rdata, ok);
    if (!ok) begin
      bad_count++;
      $display("[FAIL] bus answer expected done seen timeout");
      final_report();
    end
  endtask

  task automatic pulse_len(output int n_hi);
    int n;
    n_hi = 0;
    for (n = 0; n < 10 && chip_reset !== 1'b1; n++) @(posedge ref_clk);
    for (n = 0; n < 1000 && chip_reset === 1'b1; n++) begin
      @(posedge ref_clk);
      n_hi++;
    end
    if (n_hi >= 1000) begin
      bad_count++;
      $display("[FAIL] pulse end expected done seen timeout");
      final_report();
    end
  endtask

  function automatic logic [31:0] ctrl_model(input logic [15:0] w, input logic lvl);
    return {26'h0, w[4], w[3], w[0], w[2:1], lvl};
  endfunction

  function automatic logic [6:0] gain_model(input int g, input int cal, input logic narrow,
                                            input logic clip);
    int e;
    e = g - cal + (narrow ? 17 : 8);
    if (clip) begin
      e = (e < 12) ? 12 : (e > 102) ? 102 : e;
    end else begin
      e = (e < 0) ? 0 : (e > 127) ? 127 : e;
    end
    return 7'(e);
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    resetn     = 1'b0;
    bad_count  = 0;
    n_compared = 0;
    seed       = 37026;
    g_exp      = 7'h00;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    check("ctrl default", 32'(ctrl), 32'h05);
    check("freq default", rx.rx_freq_word, 32'h9858);
    check("skip default", rx.rf_skip, 32'h0);
    check("pulse idle", chip_reset, 32'h0);
    $display("test defaults done");

    // Soft reset first, with level 1.8 V requested in the same word
    bus(1'b1, IDX_LEVEL_SOFT_RESET, 16'h0001, r);
    pulse_len(len);
    check("pulse length", len, SOFT_RST_CYC);
    check("level after soft reset", ctrl.serial_io_level_select, 32'h1);
    bus(1'b1, IDX_LEVEL_SOFT_RESET, 16'h0001, r);
    bus(1'b1, IDX_GENERAL_CONTROL, 16'h001F, r);
    pulse_len(len);
    check("second pulse seen", len > 0, 32'h1);
    check("ctrl after pulse", 32'(ctrl), 32'h05);
    bus(1'b1, IDX_LEVEL_SOFT_RESET, 16'h0000, r);
    repeat (2) @(posedge ref_clk);
    check("level low", ctrl.serial_io_level_select, 32'h0);
    $display("test soft reset done");

    for (i = 0; i < 6; i++) begin
      d      = 16'($random(seed));
      d[2:1] = 2'((i % 3) + 1);
      bus(1'b1, IDX_GENERAL_CONTROL, d, r);
      repeat (2) @(posedge ref_clk);
      check("ctrl fields", 32'(ctrl), ctrl_model(d, 1'b0));
    end
    $display("test general control done");

    bus(1'b1, IDX_RX_FREQ_WORD, i_host.freq_word(975000, 1'b1), r);
    repeat (2) @(posedge ref_clk);
    check("freq low band", rx.rx_freq_word, 32'h9858);
    bus(1'b1, IDX_RX_FREQ_WORD, i_host.freq_word(3276750, 1'b0), r);
    repeat (2) @(posedge ref_clk);
    check("freq top", rx.rx_freq_word, 32'hFFFF);
    d = 16'($random(seed));
    bus(1'b1, IDX_RX_FREQ_WORD, d, r);
    repeat (2) @(posedge ref_clk);
    check("freq random", rx.rx_freq_word, d);
    $display("test frequency done");

    for (i = 0; i < 16; i++) begin : gain_loop
      logic [3:0]  skip;
      logic [4:0]  cal;
      logic [6:0]  g;
      logic [15:0] thr;
      skip = 4'($random(seed));
      // Zero calibration on a top word forces wideband saturation
      cal  = (i == 4) ? 5'h00 : 5'($random(seed));
      g    = (i[3:2] == 2'h0) ? 7'h00 : (i[3:2] == 2'h1) ? 7'h7F : 7'($random(seed));
      thr  = i[1] ? {skip, 4'hF, 4'h6, 4'hA} : {skip, 4'hF, 4'hA, 4'h6};
      bus(1'b1, IDX_OFFSET_THRESHOLDS, thr, r);
      bus(1'b1, IDX_RX_BASEBAND_MODE, {7'h00, i[0], 2'h0, cal, 1'b0}, r);
      bus(1'b1, IDX_RX_GAIN_WORD, {9'h000, g}, r);
      g_exp = gain_model(g, cal, i[0], i[1]);
      repeat (3) @(posedge ref_clk);
      check("gain", rx.rx_gain_eff, g_exp);
      check("skip", rx.rf_skip, skip);
    end
    $display("test gain done");

    d = 16'(ctrl);
    bus(1'b0, IDX_GENERAL_CONTROL, 16'h0000, r);
    check("write only read", r, 32'h0);
    bus(1'b1, 6'h3F, 16'hFFFF, r);
    bus(1'b0, 6'h3F, 16'h0000, r);
    check("unmapped read", r, 32'h0);
    check("ctrl kept", 32'(ctrl), 32'(d));
    bus(1'b0, IDX_STATUS, 16'h0000, r);
    check("status gain", r[8:2], g_exp);
    check("status pulse", r[0], 32'h0);
    $display("test access done");
    final_report();
  end

endmodule
`default_nettype wire
